// [hdl/iprg_regs.sv]
// Interrupt priority registers and the control/status upper byte.
// Assumes an Avalon-MM master on core_clk and arbitration logic on the same clock.
`timescale 1ns/1ps
module iprg_regs #(
	parameter bit HAS_SERIAL_PRIO = 1'b1
) (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Avalon-MM slave.
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Arbitration status in.
	input  wire logic        arb_request_pending,
	input  wire logic [3:0]  arb_irq_level,
	// Priorities out to arbitration.
	output logic [2:0]       port2_error_prio,
	output logic [2:0]       port1_error_prio,
	output logic [2:0]       volt_detect_prio,
	output logic [2:0]       lowpower_wake_prio,
	output logic [3:0]       source_enable,
	output logic             vector_hold
);

	logic        req;
	logic        accept;
	logic        wr_serial;
	logic        wr_volt;
	logic        wr_wake;
	logic        wr_ctrl;
	logic [31:0] read_mux;
	logic        core_request_pending_reg;
	logic [3:0]  current_irq_level_reg;
	logic        vector_hold_reg;
	logic        wait_reg;
	logic [31:0] rdata_reg;

	if (HAS_SERIAL_PRIO !== 1'b0 && HAS_SERIAL_PRIO !== 1'b1) begin : g_bad_variant
		$error("HAS_SERIAL_PRIO must be 0 or 1.");
	end

	assign req    = avs_read || avs_write;
	assign accept = req && !wait_reg;

	// Writes take effect only at the edge that ends the request.
	assign wr_serial = accept && avs_write && (avs_address == iprg_pkg::OFS_SERIAL_PRIO);
	assign wr_volt   = accept && avs_write && (avs_address == iprg_pkg::OFS_VOLT_PRIO);
	assign wr_wake   = accept && avs_write && (avs_address == iprg_pkg::OFS_WAKE_PRIO);
	assign wr_ctrl   = accept && avs_write && (avs_address == iprg_pkg::OFS_CTRL_STATUS);

	iprg_prio_field #(
		.PRESENT (HAS_SERIAL_PRIO)
	) u_port2 (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.wr_en      (wr_serial && avs_byteenable[1]),
		.wr_data    (avs_writedata[iprg_pkg::PORT2_LSB +: 3]),
		.prio_reg   (port2_error_prio),
		.enable_reg (source_enable[0])
	);

	iprg_prio_field #(
		.PRESENT (HAS_SERIAL_PRIO)
	) u_port1 (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.wr_en      (wr_serial && avs_byteenable[0]),
		.wr_data    (avs_writedata[iprg_pkg::PORT1_LSB +: 3]),
		.prio_reg   (port1_error_prio),
		.enable_reg (source_enable[1])
	);

	iprg_prio_field #(
		.PRESENT (1'b1)
	) u_volt (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.wr_en      (wr_volt && avs_byteenable[0]),
		.wr_data    (avs_writedata[iprg_pkg::VOLT_LSB +: 3]),
		.prio_reg   (volt_detect_prio),
		.enable_reg (source_enable[2])
	);

	iprg_prio_field #(
		.PRESENT (1'b1)
	) u_wake (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.wr_en      (wr_wake && avs_byteenable[0]),
		.wr_data    (avs_writedata[iprg_pkg::WAKE_LSB +: 3]),
		.prio_reg   (lowpower_wake_prio),
		.enable_reg (source_enable[3])
	);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			vector_hold_reg <= iprg_pkg::HOLD_RESET;
		end else if (wr_ctrl && avs_byteenable[1]) begin
			vector_hold_reg <= avs_writedata[iprg_pkg::HOLD_BIT];
		end
	end
	assign vector_hold = vector_hold_reg;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			core_request_pending_reg <= iprg_pkg::PEND_RESET;
			current_irq_level_reg    <= iprg_pkg::LEVEL_RESET;
		end else begin
			core_request_pending_reg <= arb_request_pending;
			current_irq_level_reg    <= arb_irq_level;
		end
	end

	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (avs_address)
			iprg_pkg::OFS_SERIAL_PRIO: begin
				read_mux[iprg_pkg::PORT2_LSB +: 3] = port2_error_prio;
				read_mux[iprg_pkg::PORT1_LSB +: 3] = port1_error_prio;
			end
			iprg_pkg::OFS_VOLT_PRIO: begin
				read_mux[iprg_pkg::VOLT_LSB +: 3] = volt_detect_prio;
			end
			iprg_pkg::OFS_WAKE_PRIO: begin
				read_mux[iprg_pkg::WAKE_LSB +: 3] = lowpower_wake_prio;
			end
			iprg_pkg::OFS_CTRL_STATUS: begin
				read_mux[iprg_pkg::PEND_BIT]                   = core_request_pending_reg;
				read_mux[iprg_pkg::HOLD_BIT]                   = vector_hold_reg;
				read_mux[iprg_pkg::LEVEL_LSB +: iprg_pkg::LEVEL_W] = current_irq_level_reg;
			end
			default: begin
				read_mux = 32'h0000_0000;
			end
		endcase
	end

	// Waitrequest drops for one cycle after a request is seen; read data load then.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wait_reg <= iprg_pkg::WAIT_RESET;
		end else if (req && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			rdata_reg <= iprg_pkg::RDATA_RESET;
		end else if (avs_read && wait_reg) begin
			rdata_reg <= read_mux;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;

	// Checks.
	logic [4:0] s_acc;
	assign s_acc = avs_address;

	property p_level_decode;
		@(posedge core_clk) disable iff (!rst_b)
		source_enable[2] == (volt_detect_prio != 3'h0);
	endproperty
	a_level_decode: assert property (p_level_decode)
		else $error("Voltage detect enable wrong for its priority.");

	property p_port2_write;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_serial && avs_byteenable[1]) |=>
			port2_error_prio == (HAS_SERIAL_PRIO ? $past(avs_writedata[10:8]) : 3'h0);
	endproperty
	a_port2_write: assert property (p_port2_write)
		else $error("Second port priority did not take bits 10:8.");

	property p_port1_write;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_serial && avs_byteenable[0]) |=>
			port1_error_prio == (HAS_SERIAL_PRIO ? $past(avs_writedata[6:4]) : 3'h0);
	endproperty
	a_port1_write: assert property (p_port1_write)
		else $error("First port priority did not take bits 6:4.");

	property p_volt_read;
		@(posedge core_clk) disable iff (!rst_b)
		(accept && avs_read && s_acc == iprg_pkg::OFS_VOLT_PRIO) |->
			(avs_readdata == {29'h0, volt_detect_prio});
	endproperty
	a_volt_read: assert property (p_volt_read)
		else $error("Voltage detect register read wrong.");

	property p_wake_write;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_wake && avs_byteenable[0]) |=> lowpower_wake_prio == $past(avs_writedata[2:0]);
	endproperty
	a_wake_write: assert property (p_wake_write)
		else $error("Wake-up priority did not take bits 2:0.");

	property p_reset_level;
		@(posedge core_clk)
		!rst_b |=> (volt_detect_prio == 3'h4 && lowpower_wake_prio == 3'h4 &&
			port1_error_prio == (HAS_SERIAL_PRIO ? 3'h4 : 3'h0));
	endproperty
	a_reset_level: assert property (p_reset_level)
		else $error("Priority fields not at level four after reset.");

	property p_serial_zero;
		@(posedge core_clk) disable iff (!rst_b)
		(accept && avs_read && s_acc == iprg_pkg::OFS_SERIAL_PRIO) |->
			(avs_readdata[31:11] == 21'h0 && avs_readdata[7] == 1'b0 &&
			avs_readdata[3:0] == 4'h0);
	endproperty
	a_serial_zero: assert property (p_serial_zero)
		else $error("Unimplemented serial register bits read nonzero.");

	property p_status_read;
		@(posedge core_clk) disable iff (!rst_b)
		(accept && avs_read && s_acc == iprg_pkg::OFS_CTRL_STATUS) |->
			(avs_readdata[14] == 1'b0 && avs_readdata[12] == 1'b0 &&
			avs_readdata[13] == vector_hold_reg);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("Status byte read wrong.");

	property p_hold_stable;
		@(posedge core_clk) disable iff (!rst_b)
		!wr_serial |=> $stable(port2_error_prio) && $stable(port1_error_prio);
	endproperty
	a_hold_stable: assert property (p_hold_stable)
		else $error("Serial priority changed without a write.");

	property p_level_follows;
		@(posedge core_clk) disable iff (!rst_b)
		##1 (current_irq_level_reg == $past(arb_irq_level) &&
			core_request_pending_reg == $past(arb_request_pending));
	endproperty
	a_level_follows: assert property (p_level_follows)
		else $error("Level or pending not tracking arbitration.");

	property p_answer_bound;
		@(posedge core_clk) disable iff (!rst_b)
		req |-> ##[0:1] !avs_waitrequest;
	endproperty
	a_answer_bound: assert property (p_answer_bound)
		else $error("Bus answer later than one cycle.");

	property p_wake_read;
		@(posedge core_clk) disable iff (!rst_b)
		(accept && avs_read && s_acc == iprg_pkg::OFS_WAKE_PRIO) |->
			(avs_readdata == {29'h0, lowpower_wake_prio});
	endproperty
	a_wake_read: assert property (p_wake_read)
		else $error("Wake-up register read wrong.");

	property p_unmapped_read;
		@(posedge core_clk) disable iff (!rst_b)
		(accept && avs_read && s_acc != iprg_pkg::OFS_SERIAL_PRIO &&
			s_acc != iprg_pkg::OFS_VOLT_PRIO && s_acc != iprg_pkg::OFS_WAKE_PRIO &&
			s_acc != iprg_pkg::OFS_CTRL_STATUS) |-> (avs_readdata == 32'h0000_0000);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("Unmapped address read nonzero.");

	property p_hold_write;
		@(posedge core_clk) disable iff (!rst_b)
		(wr_ctrl && avs_byteenable[1]) |=> vector_hold_reg == $past(avs_writedata[13]);
	endproperty
	a_hold_write: assert property (p_hold_write)
		else $error("Hold bit did not take bit 13.");

	property p_status_level;
		@(posedge core_clk) disable iff (!rst_b)
		(accept && avs_read && s_acc == iprg_pkg::OFS_CTRL_STATUS) |->
			(avs_readdata[15] == $past(core_request_pending_reg) &&
			avs_readdata[11:8] == $past(current_irq_level_reg) &&
			avs_readdata[7:0] == 8'h00 && avs_readdata[31:16] == 16'h0000);
	endproperty
	a_status_level: assert property (p_status_level)
		else $error("Status level or pending read wrong.");

	c_read_serial: cover property (@(posedge core_clk) disable iff (!rst_b)
		accept && avs_read && s_acc == iprg_pkg::OFS_SERIAL_PRIO);
	c_write_wake: cover property (@(posedge core_clk) disable iff (!rst_b)
		wr_wake && avs_writedata[2:0] == 3'h0);
	c_level_change: cover property (@(posedge core_clk) disable iff (!rst_b)
		$changed(current_irq_level_reg));
	c_status_pending: cover property (@(posedge core_clk) disable iff (!rst_b)
		accept && avs_read && s_acc == iprg_pkg::OFS_CTRL_STATUS && avs_readdata[15]);

endmodule : iprg_regs

// [hdl/iprg_pkg.sv]
// Constants for the interrupt priority register slice.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package iprg_pkg;

	// Register byte offsets on the bus.
	localparam logic [4:0] OFS_SERIAL_PRIO  = 5'h00;
	localparam logic [4:0] OFS_VOLT_PRIO    = 5'h04;
	localparam logic [4:0] OFS_WAKE_PRIO    = 5'h08;
	localparam logic [4:0] OFS_CTRL_STATUS  = 5'h0c;

	// Priority field width, layout and value after reset (level 4).
	localparam int         PRIO_W           = 3;
	localparam logic [2:0] PRIO_RESET       = 3'h4;
	localparam logic [2:0] PRIO_OFF         = 3'h0;
	localparam int         PORT2_LSB        = 8;
	localparam int         PORT1_LSB        = 4;
	localparam int         VOLT_LSB         = 0;
	localparam int         WAKE_LSB         = 0;

	// Control and status register upper-byte layout.
	localparam int         PEND_BIT         = 15;
	localparam int         HOLD_BIT         = 13;
	localparam int         LEVEL_LSB        = 8;
	localparam int         LEVEL_W          = 4;
	localparam logic       HOLD_RESET       = 1'b0;
	localparam logic       PEND_RESET       = 1'b0;
	localparam logic [3:0] LEVEL_RESET      = 4'h0;

	// Bus answer values after reset.
	localparam logic        WAIT_RESET      = 1'b1;
	localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;

endpackage : iprg_pkg

// [hdl/iprg_prio_field.sv]
// One three-bit priority field with its enable decode.
// Assumes the write strobe and data come from the bus slave on the same clock.
`timescale 1ns/1ps
module iprg_prio_field #(
	parameter bit PRESENT = 1'b1
) (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Write side.
	input  wire logic       wr_en,
	input  wire logic [2:0] wr_data,
	// Field outputs.
	output logic [2:0]      prio_reg,
	output logic            enable_reg
);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			prio_reg   <= PRESENT ? iprg_pkg::PRIO_RESET : iprg_pkg::PRIO_OFF;
			enable_reg <= PRESENT;
		end else if (wr_en && PRESENT) begin
			prio_reg   <= wr_data;
			enable_reg <= (wr_data != iprg_pkg::PRIO_OFF);
		end
	end

	property p_enable_matches;
		@(posedge core_clk) disable iff (!rst_b)
		enable_reg == (prio_reg != iprg_pkg::PRIO_OFF);
	endproperty
	a_enable_matches: assert property (p_enable_matches)
		else $error("Source enable disagrees with priority value.");

	property p_absent_zero;
		@(posedge core_clk) disable iff (!rst_b)
		!PRESENT |-> (prio_reg == iprg_pkg::PRIO_OFF && !enable_reg);
	endproperty
	a_absent_zero: assert property (p_absent_zero)
		else $error("Absent field does not read as zero.");

endmodule : iprg_prio_field

// [verif/iprg_arb_model.sv]
// Arbitration side model feeding the pending flag and current level.
// Assumes the bench commands each new level and flag on core_clk.
`timescale 1ns/1ps
module iprg_arb_model (
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Commands from the bench.
	input  wire logic       pending_cmd,
	input  wire logic [3:0] level_cmd,
	// Status toward the register slice.
	output logic            arb_request_pending,
	output logic [3:0]      arb_irq_level
);
	// Status registers that only the arbitration changes.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			arb_request_pending <= 1'b0;
			arb_irq_level       <= 4'h0;
		end else begin
			arb_request_pending <= pending_cmd;
			arb_irq_level       <= level_cmd;
		end
	end
endmodule // iprg_arb_model

// [verif/iprg_regs_tb.sv]
// Self-checking bench for the interrupt priority register slice.
// Assumes a full and a reduced instance sharing one Avalon-MM master.
`timescale 1ns/1ps
module iprg_regs_tb;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, red_readdata;
	logic        avs_waitrequest, red_waitrequest;
	logic        arb_request_pending, pending_cmd = 1'b0;
	logic [3:0]  arb_irq_level, level_cmd = 4'h0;
	logic [2:0]  p2, p1, pv, pw, r2;
	logic [3:0]  en, ren;
	logic        hold;
	logic [31:0] rd, rd_red;
	int          failures = 0;
	int          total_checks = 0;

	always #10 core_clk = ~core_clk;

	iprg_arb_model u_arb (.core_clk(core_clk), .rst_b(rst_b), .pending_cmd(pending_cmd),
		.level_cmd(level_cmd), .arb_request_pending(arb_request_pending),
		.arb_irq_level(arb_irq_level));

	iprg_regs u_dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .arb_request_pending(arb_request_pending),
		.arb_irq_level(arb_irq_level), .port2_error_prio(p2), .port1_error_prio(p1),
		.volt_detect_prio(pv), .lowpower_wake_prio(pw), .source_enable(en),
		.vector_hold(hold));

	iprg_regs #(.HAS_SERIAL_PRIO(1'b0)) u_red (.core_clk(core_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(red_readdata), .avs_waitrequest(red_waitrequest),
		.arb_request_pending(arb_request_pending), .arb_irq_level(arb_irq_level),
		.port2_error_prio(r2), .port1_error_prio(), .volt_detect_prio(),
		.lowpower_wake_prio(), .source_enable(ren), .vector_hold());

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One bus transfer, held until waitrequest is sampled low.
	task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge core_clk);
		avs_address    <= a;
		avs_write      <= w;
		avs_read       <= !w;
		avs_writedata  <= d;
		avs_byteenable <= be;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0 || red_waitrequest !== 1'b0);
		rd = avs_readdata;
		rd_red = red_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0, 4'h0);
		chk(rd, exp);
	endtask

	task automatic t_reset;
		rd_chk(iprg_pkg::OFS_SERIAL_PRIO, 32'h0000_0440);
		chk(rd_red, 32'h0);
		rd_chk(iprg_pkg::OFS_VOLT_PRIO, 32'h0000_0004);
		rd_chk(iprg_pkg::OFS_WAKE_PRIO, 32'h0000_0004);
		rd_chk(iprg_pkg::OFS_CTRL_STATUS, 32'h0);
		chk({en, ren}, 8'hfc);
	endtask

	task automatic t_all_ones;
		bus(iprg_pkg::OFS_SERIAL_PRIO, 1'b1, 32'hffff_ffff, 4'hf);
		bus(iprg_pkg::OFS_VOLT_PRIO, 1'b1, 32'hffff_ffff, 4'hf);
		bus(iprg_pkg::OFS_WAKE_PRIO, 1'b1, 32'hffff_ffff, 4'hf);
		rd_chk(iprg_pkg::OFS_SERIAL_PRIO, 32'h0000_0770);
		chk(rd_red, 32'h0);
		chk({r2, ren}, 7'h0c);
		rd_chk(iprg_pkg::OFS_VOLT_PRIO, 32'h0000_0007);
		rd_chk(iprg_pkg::OFS_WAKE_PRIO, 32'h0000_0007);
		chk({p2, p1, pv, pw}, 12'hfff);
	endtask

	task automatic t_lanes_and_off;
		bus(iprg_pkg::OFS_SERIAL_PRIO, 1'b1, 32'h0000_0050, 4'h1);
		rd_chk(iprg_pkg::OFS_SERIAL_PRIO, 32'h0000_0750);
		bus(iprg_pkg::OFS_SERIAL_PRIO, 1'b1, 32'h0000_0100, 4'h3);
		rd_chk(iprg_pkg::OFS_SERIAL_PRIO, 32'h0000_0100);
		chk({p2, p1, en}, 10'h08d);
		bus(iprg_pkg::OFS_VOLT_PRIO, 1'b1, 32'h0000_0000, 4'hf);
		@(posedge core_clk);
		chk({pv, en[2]}, 4'h0);
	endtask

	task automatic t_status;
		pending_cmd <= 1'b1;
		level_cmd   <= 4'ha;
		bus(iprg_pkg::OFS_CTRL_STATUS, 1'b1, 32'h0000_ffff, 4'hf);
		@(posedge core_clk);
		chk(hold, 1'b1);
		rd_chk(iprg_pkg::OFS_CTRL_STATUS, 32'h0000_aa00);
		bus(iprg_pkg::OFS_CTRL_STATUS, 1'b1, 32'h0000_0000, 4'hf);
		rd_chk(iprg_pkg::OFS_CTRL_STATUS, 32'h0000_8a00);
		pending_cmd <= 1'b0;
		level_cmd   <= 4'h3;
		repeat (2) @(posedge core_clk);
		rd_chk(iprg_pkg::OFS_CTRL_STATUS, 32'h0000_0300);
	endtask

	task automatic t_unmapped;
		bus(5'h10, 1'b1, 32'hffff_ffff, 4'hf);
		rd_chk(5'h10, 32'h0);
		rd_chk(iprg_pkg::OFS_WAKE_PRIO, 32'h0000_0007);
	endtask

	task automatic t_reset_again;
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		rd_chk(iprg_pkg::OFS_SERIAL_PRIO, 32'h0000_0440);
		chk(en, 4'hf);
		rd_chk(iprg_pkg::OFS_WAKE_PRIO, 32'h0000_0004);
	endtask

	task automatic conclude;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		t_reset();
		t_all_ones();
		t_lanes_and_off();
		t_status();
		t_unmapped();
		t_reset_again();
		conclude();
	end

	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		conclude();
	end
endmodule // iprg_regs_tb
